// ==== verilog/config_word_pkg.sv ====
// Shared constants for the configuration word block
package config_word_pkg;

  // Widths
  localparam int ADDR_W    = 16;
  localparam int WORD_W    = 14;
  localparam int CFG_W     = 16;
  localparam int PAYLOAD_W = 8;
  localparam int NUM_CFG   = 5;
  localparam int NUM_UID   = 4;

  // Address map
  localparam logic [15:0] UID_BASE    = 16'h8000;
  localparam logic [15:0] UID_LAST    = 16'h8003;
  localparam logic [15:0] REV_ID_ADDR = 16'h8005;
  localparam logic [15:0] DEV_ID_ADDR = 16'h8006;
  localparam logic [15:0] CFG_BASE    = 16'h8007;
  localparam logic [15:0] CFG_LAST    = 16'h800B;
  localparam logic [15:0] EE_BASE     = 16'hF000;
  localparam logic [15:0] EE_LAST     = 16'hF0FF;

  // Sampling walk over the low nibble of 0x8000..0x800B
  localparam logic [11:0] SAMPLE_PAGE = 12'h800;
  localparam logic [3:0]  SAMPLE_LAST = 4'hB;
  localparam logic [3:0]  UID_LAST_IDX = 4'h3;
  localparam logic [3:0]  CFG_FIRST_IDX = 4'h7;

  // Identity words, values arbitrary
  localparam logic [13:0] DEV_ID_VALUE = 14'h0A5C;
  localparam logic [13:0] REV_ID_VALUE = 14'h0042;

  // Oscillator configuration word fields
  localparam int FCM_BIT       = 13;
  localparam int ANALOG_SUPPLY_RANGE_SEL_BIT     = 12;
  localparam int CSW_BIT       = 11;
  localparam int CLOCK_OUTPUT_PIN_BIT    = 8;
  localparam int BOOT_OSC_LSB  = 4;
  localparam int EXT_MODE_LSB  = 0;
  localparam logic [15:0] OSC_CFG_MASK = 16'h3977;
  localparam logic [15:0] WORD_MASK    = 16'h3FFF;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

  // Protection fields
  localparam logic [2:0] GUARD_CFG     = 3'h4;
  localparam int         FLASH_GUARD_BIT  = 0;
  localparam int         EEPROM_GUARD_BIT = 1;
  localparam logic [2:0] WR_GUARD_CFG  = 3'h3;
  localparam int         BLOCK_MSB     = 14;
  localparam int         BLOCK_LSB     = 13;
  localparam int         ERASE_CLR_PROT_BIT = 4;

  // Boot oscillator codes
  localparam logic [2:0] BOOT_EXT      = 3'h7;
  localparam logic [2:0] BOOT_FAST_1M  = 3'h6;
  localparam logic [2:0] BOOT_SLOW     = 3'h5;
  localparam logic [2:0] BOOT_SECOND   = 3'h4;
  localparam logic [2:0] BOOT_EXT_PLL  = 3'h2;
  localparam logic [2:0] BOOT_FAST_16M = 3'h1;
  localparam logic [2:0] BOOT_FAST_32M = 3'h0;

  // External oscillator mode codes
  localparam logic [2:0] EXT_CLK_HIGH  = 3'h7;
  localparam logic [2:0] EXT_CLK_LOW   = 3'h5;
  localparam logic [2:0] EXT_OFF       = 3'h4;
  localparam logic [2:0] EXT_XTAL_HS   = 3'h2;
  localparam logic [2:0] EXT_XTAL_MID  = 3'h1;
  localparam logic [2:0] EXT_XTAL_32K  = 3'h0;

  // Fast oscillator frequency and post divider codes
  localparam logic [1:0] FRQ_4M  = 2'h0;
  localparam logic [1:0] FRQ_16M = 2'h1;
  localparam logic [1:0] FRQ_32M = 2'h2;
  localparam logic [3:0] DIV_1   = 4'h0;
  localparam logic [3:0] DIV_4   = 4'h2;

endpackage

// ==== verilog/config_sampler.sv ====
// Walks the nonvolatile configuration area once after reset
`timescale 1ns/1ps
`default_nettype none
module config_sampler (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Nonvolatile read port
  output logic             nv_rd_req,
  output logic [15:0]      nv_rd_addr,
  input  wire logic [15:0] nv_rd_data,
  // Captured words
  output logic             cap_valid,
  output logic [3:0]       cap_index,
  output logic [15:0]      cap_data,
  output logic             sample_done
);

  typedef enum logic [1:0] {st_walk, st_drain, st_done} state_type;

  state_type  state;
  logic [3:0] walk_idx;
  logic       rd_pend;
  logic [3:0] pend_idx;

  assign nv_rd_req  = (state == st_walk);
  assign nv_rd_addr = {config_word_pkg::SAMPLE_PAGE, walk_idx};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= st_walk;
      walk_idx <= 4'h0;
    end else if (clk_en) begin
      unique case (state)
        st_walk: begin
          if (walk_idx == config_word_pkg::SAMPLE_LAST) begin
            state <= st_drain;
          end else begin
            walk_idx <= walk_idx + 4'h1;
          end
        end
        st_drain: begin
          if (!rd_pend && !cap_valid) begin
            state <= st_done;
          end
        end
        st_done: begin
          state <= st_done;
        end
      endcase
    end
  end

  // Read data arrives one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend   <= 1'b0;
      pend_idx  <= 4'h0;
      cap_valid <= 1'b0;
      cap_index <= 4'h0;
      cap_data  <= 16'h0000;
    end else if (clk_en) begin
      rd_pend   <= nv_rd_req;
      pend_idx  <= walk_idx;
      cap_valid <= rd_pend;
      cap_index <= pend_idx;
      cap_data  <= nv_rd_data;
    end
  end

  assign sample_done = (state == st_done);

endmodule // config_sampler
`default_nettype wire

// ==== verilog/clock_output_pin_ctrl.sv ====
// Clock output pin: Fosc/4 or plain I/O
`timescale 1ns/1ps
`default_nettype none
module clock_output_pin_ctrl (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Control
  input  wire logic cycle_clock_output_n,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  output logic      gpio_in,
  // Pin
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe
);

  logic [1:0] div_cnt;
  logic       pin_meta;
  logic       pin_sync;
  logic       out_q;
  logic       oe_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
    end else if (clk_en) begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else if (clk_en) begin
      out_q <= cycle_clock_output_n ? gpio_out : div_cnt[1];
      oe_q  <= cycle_clock_output_n ? gpio_oe : 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (clk_en) begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  assign pin_out = out_q;
  assign pin_oe  = oe_q;
  assign gpio_in = pin_sync;

endmodule // clock_output_pin_ctrl
`default_nettype wire

// ==== verilog/config_word_protection.sv ====
// Configuration words, identity words and memory protection
// What this block does
// - Five configuration words live at 0x8007 to 0x800B.
// - Protected flash and EEPROM read as zero by the programmer.
// - Protected memory refuses programmer writes until a bulk erase with payload bit 4 set or a programmer write to the guard word at 0x800B.
// - Running software reads and writes memory regardless of code protection.
// - User IDs and configuration words stay programmable and readable always.
// - Bulk erase with payload bit 4 set clears protection and erases all.
// - Self-writes into guarded program blocks are blocked, others allowed.
// - Four user_ident_word0 words at 8000h-8003h, read and write by software.
// - 14-bit identity words at 8006h and 8005h, read only.
// - Clock failure monitor follows bit 13 of the oscillator word.
// - Analog range bit picks the 2.3-5.5V or 1.8-3.6V calibration.
// - Oscillator switch writes take effect only while the permit is one.
// - Clock output bit zero drives Fosc/4, one gives plain I/O.
// - Boot oscillator field loads current and next oscillator at power-up.
// - External mode field selects high, low external clock or off.
// - Unimplemented configuration bits read as zero.
// - External codes 010, 001, 000 select crystal ranges.
`timescale 1ns/1ps
`default_nettype none
module config_word_protection (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Nonvolatile sampling port
  output logic             nv_rd_req,
  output logic [15:0]      nv_rd_addr,
  input  wire logic [15:0] nv_rd_data,
  // Programmer port
  input  wire logic        prog_req,
  input  wire logic        prog_we,
  input  wire logic [15:0] prog_addr,
  input  wire logic [13:0] prog_wdata,
  input  wire logic        prog_erase,
  input  wire logic [7:0]  prog_payload,
  output logic             prog_ready,
  output logic             prog_ack,
  output logic             prog_refused,
  output logic [13:0]      prog_rdata,
  // Running software port
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [13:0] cpu_wdata,
  output logic             cpu_ready,
  output logic             cpu_ack,
  output logic             cpu_refused,
  output logic [13:0]      cpu_rdata,
  // Memory array port
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [13:0]      mem_wdata,
  input  wire logic [13:0] mem_rdata,
  output logic             mem_bulk_erase,
  // Oscillator switch requests from software
  input  wire logic        sw_osc_wr,
  input  wire logic [2:0]  sw_next_osc,
  input  wire logic [3:0]  sw_next_div,
  // Decoded settings
  output logic             config_ready,
  output logic [2:0]       current_osc_select,
  output logic [2:0]       next_osc_select,
  output logic [3:0]       next_clock_divider,
  output logic [1:0]       fast_osc_freq_sel,
  output logic             pll_x4_on,
  output logic [2:0]       external_osc_mode,
  output logic             ext_clock_high,
  output logic             ext_clock_low,
  output logic             high_speed_crystal,
  output logic             mid_range_crystal,
  output logic             watch_crystal,
  output logic             off_chip_osc_on,
  output logic             clock_failure_monitor_on,
  output logic             analog_supply_range_sel,
  output logic             osc_switch_permit,
  // Clock output pin
  input  wire logic        gpio_out,
  input  wire logic        gpio_oe,
  output logic             gpio_in,
  input  wire logic        clock_output_pin_in,
  output logic             clock_output_pin_out,
  output logic             clock_output_pin_oe
);

  // Address decoding
  function automatic logic is_flash(input logic [15:0] a);
    return a < config_word_pkg::UID_BASE;
  endfunction

  function automatic logic is_eeprom(input logic [15:0] a);
    return (a >= config_word_pkg::EE_BASE) && (a <= config_word_pkg::EE_LAST);
  endfunction

  function automatic logic is_uid(input logic [15:0] a);
    return (a >= config_word_pkg::UID_BASE) && (a <= config_word_pkg::UID_LAST);
  endfunction

  function automatic logic is_cfg(input logic [15:0] a);
    return (a >= config_word_pkg::CFG_BASE) && (a <= config_word_pkg::CFG_LAST);
  endfunction

  function automatic logic [15:0] cfg_mask(input logic [2:0] i);
    return (i == 3'h0) ? config_word_pkg::OSC_CFG_MASK : config_word_pkg::WORD_MASK;
  endfunction

  // Sampled storage
  logic [15:0] cfg_word [config_word_pkg::NUM_CFG];
  logic [13:0] uid_word [config_word_pkg::NUM_UID];
  logic [15:0] osc_word;

  // Sampler outputs
  logic        cap_valid;
  logic [3:0]  cap_index;
  logic [15:0] cap_data;
  logic        sample_done;

  // Stage one
  logic        s1_valid;
  logic        s1_prog;
  logic        s1_refuse;
  logic        s1_zero;
  logic        s1_mem_rd;
  logic [13:0] s1_idata;

  // Request selection
  logic        sel_prog;
  logic        take_erase;
  logic        take_acc;
  logic        take_any;
  logic [15:0] req_addr;
  logic        req_we;
  logic [13:0] req_wdata;
  logic        req_flash;
  logic        req_ee;
  logic        req_uid;
  logic        req_cfg;
  logic        req_id;
  logic [2:0]  req_cfg_idx;
  logic [1:0]  req_uid_idx;
  logic        flash_guard;
  logic        eeprom_guard;
  logic        block_wr_ok;
  logic        erase_all;
  logic        req_refuse;
  logic        req_zero;
  logic        req_mem;
  logic [13:0] req_idata;
  logic [2:0]  cap_cfg_idx;
  logic [2:0]  boot_code;
  logic [15:0] cfg_rd_word;

  config_sampler u_sampler (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .nv_rd_req   (nv_rd_req),
    .nv_rd_addr  (nv_rd_addr),
    .nv_rd_data  (nv_rd_data),
    .cap_valid   (cap_valid),
    .cap_index   (cap_index),
    .cap_data    (cap_data),
    .sample_done (sample_done)
  );

  clock_output_pin_ctrl u_clock_output_pin (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .clk_en               (clk_en),
    .cycle_clock_output_n (osc_word[config_word_pkg::CLOCK_OUTPUT_PIN_BIT]),
    .gpio_out             (gpio_out),
    .gpio_oe              (gpio_oe),
    .gpio_in              (gpio_in),
    .pin_in               (clock_output_pin_in),
    .pin_out              (clock_output_pin_out),
    .pin_oe               (clock_output_pin_oe)
  );

  // Handshake
  assign config_ready = sample_done;
  assign prog_ready   = sample_done && !s1_valid;
  assign cpu_ready    = prog_ready && !prog_req && !prog_erase;
  assign take_erase   = prog_erase && prog_ready;
  assign sel_prog     = prog_req || prog_erase;
  assign take_acc     = (prog_req && prog_ready && !prog_erase) || (cpu_req && cpu_ready);
  assign take_any     = take_erase || take_acc;

  // Request decode
  assign req_addr    = sel_prog ? prog_addr : cpu_addr;
  assign req_we      = sel_prog ? prog_we : cpu_we;
  assign req_wdata   = sel_prog ? prog_wdata : cpu_wdata;
  assign req_flash   = is_flash(req_addr);
  assign req_ee      = is_eeprom(req_addr);
  assign req_uid     = is_uid(req_addr);
  assign req_cfg     = is_cfg(req_addr);
  assign req_id      = (req_addr == config_word_pkg::REV_ID_ADDR) || (req_addr == config_word_pkg::DEV_ID_ADDR);
  assign req_cfg_idx = 3'(req_addr[3:0] - config_word_pkg::CFG_FIRST_IDX);
  assign req_uid_idx = req_addr[1:0];

  // Protection state
  assign flash_guard  = !cfg_word[config_word_pkg::GUARD_CFG][config_word_pkg::FLASH_GUARD_BIT];
  assign eeprom_guard = !cfg_word[config_word_pkg::GUARD_CFG][config_word_pkg::EEPROM_GUARD_BIT];
  assign block_wr_ok  = cfg_word[config_word_pkg::WR_GUARD_CFG][req_addr[config_word_pkg::BLOCK_MSB:
                                                                          config_word_pkg::BLOCK_LSB]];
  assign erase_all    = prog_payload[config_word_pkg::ERASE_CLR_PROT_BIT];

  assign req_refuse = prog_erase ? (!erase_all && (flash_guard || eeprom_guard)) :
                      req_flash  ? (req_we && (sel_prog ? flash_guard : !block_wr_ok)) :
                      req_ee     ? (req_we && sel_prog && eeprom_guard) :
                      req_uid    ? 1'b0 :
                      req_id     ? req_we :
                      req_cfg    ? (req_we && !sel_prog) :
                      1'b1;
  assign req_zero   = sel_prog && !req_we && ((req_flash && flash_guard) || (req_ee && eeprom_guard));
  assign req_mem    = !prog_erase && (req_flash || req_ee) && !req_refuse;

  // Internal read data
  assign cfg_rd_word = cfg_word[req_cfg_idx] & cfg_mask(req_cfg_idx);
  assign req_idata = req_uid ? uid_word[req_uid_idx] :
                     (req_addr == config_word_pkg::REV_ID_ADDR) ? config_word_pkg::REV_ID_VALUE :
                     (req_addr == config_word_pkg::DEV_ID_ADDR) ? config_word_pkg::DEV_ID_VALUE :
                     req_cfg ? cfg_rd_word[13:0] :
                     14'h0000;

  // Sampled word bookkeeping
  assign cap_cfg_idx = 3'(cap_index - config_word_pkg::CFG_FIRST_IDX);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < config_word_pkg::NUM_CFG; i++) begin
        cfg_word[i] <= config_word_pkg::ERASED_WORD;
      end
    end else if (clk_en) begin
      if (cap_valid && cap_index >= config_word_pkg::CFG_FIRST_IDX) begin
        cfg_word[cap_cfg_idx] <= cap_data & cfg_mask(cap_cfg_idx);
      end else if (take_erase && erase_all) begin
        for (int i = 0; i < config_word_pkg::NUM_CFG; i++) begin
          cfg_word[i] <= config_word_pkg::ERASED_WORD & cfg_mask(3'(i));
        end
      end else if (take_acc && req_cfg && req_we && !req_refuse) begin
        cfg_word[req_cfg_idx] <= {2'b00, req_wdata} & cfg_mask(req_cfg_idx);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < config_word_pkg::NUM_UID; i++) begin
        uid_word[i] <= config_word_pkg::ERASED_WORD[13:0];
      end
    end else if (clk_en) begin
      if (cap_valid && cap_index <= config_word_pkg::UID_LAST_IDX) begin
        uid_word[cap_index[1:0]] <= cap_data[13:0];
      end else if (take_erase && erase_all) begin
        for (int i = 0; i < config_word_pkg::NUM_UID; i++) begin
          uid_word[i] <= config_word_pkg::ERASED_WORD[13:0];
        end
      end else if (take_acc && req_uid && req_we) begin
        uid_word[req_uid_idx] <= req_wdata;
      end
    end
  end

  // Oscillator word is taken only while sampling
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_word <= config_word_pkg::ERASED_WORD & config_word_pkg::OSC_CFG_MASK;
    end else if (clk_en && cap_valid && cap_index == config_word_pkg::CFG_FIRST_IDX) begin
      osc_word <= cap_data & config_word_pkg::OSC_CFG_MASK;
    end
  end

  // Oscillator selections
  assign boot_code = cap_data[config_word_pkg::BOOT_OSC_LSB +: 3];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      current_osc_select <= config_word_pkg::BOOT_EXT;
      next_osc_select    <= config_word_pkg::BOOT_EXT;
      next_clock_divider <= config_word_pkg::DIV_1;
    end else if (clk_en) begin
      if (cap_valid && cap_index == config_word_pkg::CFG_FIRST_IDX) begin
        current_osc_select <= boot_code;
        next_osc_select    <= boot_code;
        next_clock_divider <= (boot_code == config_word_pkg::BOOT_FAST_1M) ? config_word_pkg::DIV_4 :
                              config_word_pkg::DIV_1;
      end else if (sw_osc_wr && osc_switch_permit && sample_done) begin
        next_osc_select    <= sw_next_osc;
        next_clock_divider <= sw_next_div;
      end
    end
  end

  assign fast_osc_freq_sel = (current_osc_select == config_word_pkg::BOOT_FAST_32M) ? config_word_pkg::FRQ_32M :
                             (current_osc_select == config_word_pkg::BOOT_FAST_16M) ? config_word_pkg::FRQ_16M :
                             config_word_pkg::FRQ_4M;
  assign pll_x4_on         = (current_osc_select == config_word_pkg::BOOT_EXT_PLL);

  // External oscillator mode
  assign external_osc_mode  = osc_word[config_word_pkg::EXT_MODE_LSB +: 3];
  assign ext_clock_high     = (external_osc_mode == config_word_pkg::EXT_CLK_HIGH);
  assign ext_clock_low      = (external_osc_mode == config_word_pkg::EXT_CLK_LOW);
  assign high_speed_crystal = (external_osc_mode == config_word_pkg::EXT_XTAL_HS);
  assign mid_range_crystal  = (external_osc_mode == config_word_pkg::EXT_XTAL_MID);
  assign watch_crystal      = (external_osc_mode == config_word_pkg::EXT_XTAL_32K);
  assign off_chip_osc_on    = ext_clock_high || ext_clock_low || high_speed_crystal ||
                              mid_range_crystal || watch_crystal;

  // Single-bit settings
  assign clock_failure_monitor_on = osc_word[config_word_pkg::FCM_BIT];
  assign analog_supply_range_sel  = osc_word[config_word_pkg::ANALOG_SUPPLY_RANGE_SEL_BIT];
  assign osc_switch_permit        = osc_word[config_word_pkg::CSW_BIT];

  // Stage one and memory request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid  <= 1'b0;
      s1_prog   <= 1'b0;
      s1_refuse <= 1'b0;
      s1_zero   <= 1'b0;
      s1_mem_rd <= 1'b0;
      s1_idata  <= 14'h0000;
    end else if (clk_en) begin
      s1_valid  <= take_any;
      s1_prog   <= sel_prog;
      s1_refuse <= req_refuse;
      s1_zero   <= req_zero;
      s1_mem_rd <= req_mem && !req_we;
      s1_idata  <= req_idata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req        <= 1'b0;
      mem_we         <= 1'b0;
      mem_addr       <= 16'h0000;
      mem_wdata      <= 14'h0000;
      mem_bulk_erase <= 1'b0;
    end else if (clk_en) begin
      mem_req        <= take_acc && req_mem;
      mem_we         <= take_acc && req_mem && req_we;
      mem_addr       <= req_addr;
      mem_wdata      <= req_wdata;
      mem_bulk_erase <= take_erase && !req_refuse;
    end
  end

  // Answers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_ack     <= 1'b0;
      prog_refused <= 1'b0;
      prog_rdata   <= 14'h0000;
      cpu_ack      <= 1'b0;
      cpu_refused  <= 1'b0;
      cpu_rdata    <= 14'h0000;
    end else if (clk_en) begin
      prog_ack    <= s1_valid && s1_prog;
      cpu_ack     <= s1_valid && !s1_prog;
      prog_refused <= s1_valid && s1_prog && s1_refuse;
      cpu_refused  <= s1_valid && !s1_prog && s1_refuse;
      if (s1_valid) begin
        if (s1_prog) begin
          prog_rdata <= s1_zero ? 14'h0000 : (s1_mem_rd ? mem_rdata : s1_idata);
        end else begin
          cpu_rdata <= s1_mem_rd ? mem_rdata : s1_idata;
        end
      end
    end
  end

endmodule // config_word_protection
`default_nettype wire

// ==== tb/nv_store_model.sv ====
// Nonvolatile store and memory array model
`timescale 1ns/1ps
`default_nettype none
module nv_store_model (
  // Storage ports
  input  wire logic        ref_clk,
  input  wire logic [15:0] nv_rd_addr,
  output logic      [15:0] nv_rd_data,
  input  wire logic [15:0] mem_addr,
  output logic      [13:0] mem_rdata
);
  always_ff @(posedge ref_clk) begin
    case (nv_rd_addr[3:0])
      4'h7: nv_rd_data <= 16'hE0F5;
      4'hA: nv_rd_data <= 16'h3FFE;
      4'hB: nv_rd_data <= 16'h3FFC;
      default: nv_rd_data <= 16'h3FFF;
    endcase
  end
  assign mem_rdata = ~mem_addr[13:0];
endmodule // nv_store_model
`default_nettype wire

// ==== tb/config_word_protection_checker.sv ====
// Assertion checker for the configuration word block
`timescale 1ns/1ps
`default_nettype none
module cwp_checker (
  // Watched ports
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        prog_req,
  input wire logic        prog_we,
  input wire logic [15:0] prog_addr,
  input wire logic        prog_erase,
  input wire logic [7:0]  prog_payload,
  input wire logic        prog_ready,
  input wire logic        prog_ack,
  input wire logic        prog_refused,
  input wire logic        mem_bulk_erase,
  input wire logic        sw_osc_wr,
  input wire logic [2:0]  next_osc_select,
  input wire logic        osc_switch_permit,
  input wire logic        config_ready,
  input wire logic [2:0]  external_osc_mode,
  input wire logic        ext_clock_high
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ack_timing: assert property (prog_ready && (prog_req || prog_erase) |=> ##1 prog_ack) else $error("late");
  a_ack_single: assert property (prog_ack |=> !prog_ack) else $error("long ack");
  a_erase_done: assert property (prog_ready && prog_erase && prog_payload[4] |=> mem_bulk_erase ##1
    (prog_ack && !prog_refused)) else $error("bad erase");
  a_ident_ro: assert property (prog_ready && !prog_erase && prog_req && prog_we && prog_addr inside
    {16'h8005, 16'h8006} |=> ##1 prog_refused) else $error("id written");
  a_switch_lock: assert property (config_ready && $past(config_ready) && sw_osc_wr && !osc_switch_permit
    |=> $stable(next_osc_select)) else $error("switch taken");
  a_ready_holds: assert property (config_ready |=> config_ready) else $error("ready lost");
  a_ext_high: assert property (ext_clock_high == (external_osc_mode == 3'h7)) else $error("bad decode");
  a_ready_gap: assert property (prog_ready && prog_req |=> !prog_ready) else $error("no gap");
  c_erase: cover property (mem_bulk_erase);
  c_refused: cover property (prog_ack && prog_refused);
  c_osc_wr: cover property (sw_osc_wr && config_ready);
endmodule // cwp_checker
bind config_word_protection cwp_checker u_chk (.ref_clk, .rst_n, .prog_req, .prog_we, .prog_addr, .prog_erase,
  .prog_payload, .prog_ready, .prog_ack, .prog_refused, .mem_bulk_erase, .sw_osc_wr, .next_osc_select,
  .osc_switch_permit, .config_ready, .external_osc_mode, .ext_clock_high);
`default_nettype wire

// ==== tb/config_word_protection_tb.sv ====
// Testbench for the configuration word block
`timescale 1ns/1ps
`default_nettype none
module config_word_protection_tb;
  logic ref_clk = 0, rst_n = 0, prog_req = 0, cpu_req = 0, we = 0, prog_erase = 0, sw_osc_wr = 0, f;
  logic [15:0] ad = 0, nv_rd_data, nv_rd_addr, mem_addr;
  logic [13:0] wd = 0, r, mem_rdata, prog_rdata, cpu_rdata;
  logic [2:0] osw = 0, current_osc_select, next_osc_select, external_osc_mode;
  logic prog_ready, prog_ack, prog_refused, cpu_ready, cpu_ack, cpu_refused, config_ready;
  logic ext_clock_low, clock_failure_monitor_on, analog_supply_range_sel, clock_output_pin_oe;
  int err_count = 0, n_tests = 0, i;
  always #5 ref_clk = ~ref_clk;
  nv_store_model u_nv (.ref_clk, .nv_rd_addr, .nv_rd_data, .mem_addr, .mem_rdata);
  config_word_protection dut (.ref_clk, .rst_n, .clk_en(1'b1), .nv_rd_req(), .nv_rd_addr, .nv_rd_data,
    .prog_req, .prog_we(we), .prog_addr(ad), .prog_wdata(wd), .prog_erase, .prog_payload(wd[7:0]), .prog_ready,
    .prog_ack, .prog_refused, .prog_rdata, .cpu_req, .cpu_we(we), .cpu_addr(ad), .cpu_wdata(wd), .cpu_ready,
    .cpu_ack, .cpu_refused, .cpu_rdata, .mem_req(), .mem_we(), .mem_addr, .mem_wdata(), .mem_rdata,
    .mem_bulk_erase(), .sw_osc_wr, .sw_next_osc(osw), .sw_next_div({1'b0, osw}), .config_ready,
    .current_osc_select, .next_osc_select, .next_clock_divider(), .fast_osc_freq_sel(), .pll_x4_on(),
    .external_osc_mode, .ext_clock_high(), .ext_clock_low, .high_speed_crystal(), .mid_range_crystal(),
    .watch_crystal(), .off_chip_osc_on(), .clock_failure_monitor_on, .analog_supply_range_sel,
    .osc_switch_permit(), .gpio_out(1'b0), .gpio_oe(1'b0), .gpio_in(), .clock_output_pin_in(1'b0),
    .clock_output_pin_out(), .clock_output_pin_oe);
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic p, input logic e, input logic w, input logic [15:0] a, input logic [13:0] d);
    @(posedge ref_clk);
    prog_req <= p & !e;
    cpu_req <= !p;
    prog_erase <= e;
    we <= w;
    ad <= a;
    wd <= d;
    for (i = 0; i < 30 && (p ? prog_ready : cpu_ready) !== 1'b1; i++) @(negedge ref_clk);
    if (i == 30) begin err_count++; close_out(); end
    @(posedge ref_clk);
    prog_req <= 0;
    cpu_req <= 0;
    prog_erase <= 0;
    repeat (2) @(negedge ref_clk);
    r = p ? prog_rdata : cpu_rdata;
    f = p ? prog_refused : cpu_refused;
    chk(p ? prog_ack : cpu_ack, 1);
  endtask
  task automatic t_decode;
    chk(current_osc_select, 3'h7);
    chk(next_osc_select, 3'h7);
    chk(external_osc_mode, 3'h5);
    chk(ext_clock_low, 1'b1);
    chk(clock_failure_monitor_on, 1'b1);
    chk(analog_supply_range_sel, 1'b0);
    chk(clock_output_pin_oe, 1'b1);
    xfer(1, 0, 0, 16'h8007, 0);
    chk(r, 14'h2075);
  endtask
  task automatic t_switch;
    @(posedge ref_clk);
    sw_osc_wr <= 1;
    @(posedge ref_clk);
    sw_osc_wr <= 0;
    @(negedge ref_clk);
    chk(next_osc_select, 3'h7);
  endtask
  task automatic t_guard;
    xfer(1, 0, 0, 16'h0010, 0);
    chk(r, 0);
    xfer(1, 0, 1, 16'h0010, 14'h0055);
    chk(f, 1);
    xfer(0, 0, 0, 16'h0010, 0);
    chk(r, 14'h3FEF);
    xfer(0, 0, 1, 16'h0010, 0);
    chk(f, 1);
    xfer(0, 0, 1, 16'h2010, 0);
    chk(f, 0);
  endtask
  task automatic t_ident;
    xfer(1, 0, 0, 16'h8006, 0);
    chk(r, config_word_pkg::DEV_ID_VALUE);
    xfer(1, 0, 1, 16'h8005, 14'h0001);
    chk(f, 1);
    xfer(1, 0, 1, 16'h8001, 14'h1234);
    xfer(0, 0, 0, 16'h8001, 0);
    chk(r, 14'h1234);
  endtask
  task automatic t_erase;
    xfer(1, 1, 0, 0, 0);
    chk(f, 1);
    xfer(1, 1, 0, 0, 16);
    chk(f, 0);
    xfer(1, 0, 0, 16'h0010, 0);
    chk(r, 14'h3FEF);
    xfer(1, 0, 0, 16'h8001, 0);
    chk(r, 14'h3FFF);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1;
    for (i = 0; i < 40 && config_ready !== 1'b1; i++) @(negedge ref_clk);
    chk(config_ready, 1);
    t_decode();
    t_switch();
    t_guard();
    t_ident();
    t_erase();
    close_out();
  end
endmodule // config_word_protection_tb
`default_nettype wire
